// file: common/timer16_map.vh
// register map, field positions, reset values and timing constants of the 16-bit timer
// assumes a 32-bit APB slave with byte addresses of 8 bits
`ifndef TIMER16_MAP_VH
`define TIMER16_MAP_VH

// register byte offsets
`define OFF_MODE        8'h00
`define OFF_PRESCALE    8'h04
`define OFF_OUTCTL      8'h08
`define OFF_CMP_A       8'h0C
`define OFF_CMP_B       8'h10
`define OFF_COUNT       8'h14
`define OFF_IRQ_STAT    8'h18
`define OFF_IRQ_MASK    8'h1C

// operating modes in the mode register
`define MODE_STOP       2'h0
`define MODE_FREE       2'h1
`define MODE_EDGE_CLR   2'h2
`define MODE_MATCH_CLR  2'h3

// prescaler register fields
`define PS_CKS_LO       0
`define PS_CKS_HI       1
`define PS_EDGE_A_LO    2
`define PS_EDGE_A_HI    3
`define PS_EDGE_B_LO    4
`define PS_EDGE_B_HI    5
`define CKS_EDGE_A      2'h3
`define CKS_DIV2        2'h0
`define CKS_DIV8        2'h1

// valid edge codes
`define EDGE_FALL       2'h0
`define EDGE_RISE       2'h1
`define EDGE_BOTH       2'h2
`define EDGE_NONE       2'h3

// prescaler tap masks: tick when the masked divider bits are all ones
`define DIV_MASK2       8'h01
`define DIV_MASK8       8'h07
`define DIV_MASK32      8'h1F

// output control bits
`define OC_OUT_EN       0
`define OC_INV_A        1
`define OC_INV_B        2
`define OC_ONESHOT      3
`define OC_SOFT_TRIG    4
`define OC_CAP_A        5
`define OC_CAP_B        6

// interrupt status and mask bits
`define IRQ_MATCH_A     0
`define IRQ_MATCH_B     1
`define IRQ_EDGE_A      2
`define IRQ_EDGE_B      3

// reset values
`define MODE_RST        2'h0
`define PRESCALE_RST    6'h00
`define OUTCTL_RST      7'h00
`define CMP_RST         16'h0000
`define COUNT_RST       16'h0000
`define STAT_RST        4'h0
`define MASK_RST        4'hF
`define DIV_RST         8'h00

`endif

// file: logic/edge_sense.v
// valid edge detector for one timer input pin
// assumes pin is asynchronous to clk; it is synchronised here before use
`include "timer16_map.vh"
`timescale 1ns/1ps
`default_nettype none

module edge_sense (
    input  wire       clk,        // system clock
    input  wire       rst_n,      // asynchronous reset, active low
    input  wire       pin,        // raw input pin
    input  wire       enable,     // detection enabled while the counter runs
    input  wire [1:0] edge_sel,   // valid edge selection
    output reg        edge_pulse  // one-cycle pulse per valid edge
);

    reg sync1;   // first synchroniser stage
    reg sync2;   // second synchroniser stage
    reg prev;    // level seen last cycle, held low until first enable
    reg armed;   // set once the counter has been enabled after reset

    // the previous level stays low from reset until the first enable, so a pin
    // already high then gives a rising edge; after a stop it keeps tracking the
    // pin, so a re-enable with the pin high gives none
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sync1      <= 1'b0;
            sync2      <= 1'b0;
            prev       <= 1'b0;
            armed      <= 1'b0;
            edge_pulse <= 1'b0;
        end else begin
            sync1      <= pin;
            sync2      <= sync1;
            edge_pulse <= 1'b0;
            if (enable) begin
                armed <= 1'b1;
                prev  <= sync2;
                case (edge_sel)
                    `EDGE_FALL: edge_pulse <= prev & ~sync2;
                    `EDGE_RISE: edge_pulse <= sync2 & ~prev;
                    `EDGE_BOTH: edge_pulse <= sync2 ^ prev;
                    default:    edge_pulse <= 1'b0;
                endcase
            end else if (armed) begin
                prev <= sync2;
            end
        end
    end

endmodule // edge_sense

`default_nettype wire

// file: logic/timer16_ppg_oneshot_capture.v
// 16-bit timer/event counter with two compare/capture registers, APB slave
// assumes pclk at 40 MHz, edge_input_a and shared_port_pin_in asynchronous
`include "timer16_map.vh"
`timescale 1ns/1ps
`default_nettype none

module timer16_ppg_oneshot_capture #(
    parameter CW = 16               // counter width
) (
    input  wire          pclk,                  // apb clock, 40 MHz
    input  wire          presetn,               // asynchronous reset, active low
    input  wire          psel,                  // apb select
    input  wire          penable,               // apb access phase
    input  wire          pwrite,                // apb write
    input  wire [7:0]    paddr,                 // apb byte address
    input  wire [31:0]   pwdata,                // apb write data
    output reg  [31:0]   prdata,                // apb read data
    output wire          pready,                // apb ready, always high
    output wire          pslverr,               // apb error on unmapped address
    input  wire          edge_input_a,          // first valid edge input pin
    input  wire          shared_port_pin_in,    // shared pin level, second edge input
    output wire          shared_port_pin_out,   // timer output level on shared pin
    output wire          shared_port_pin_oe_n,  // low while timer drives shared pin
    output reg           irq                    // level interrupt
);

    // software registers
    reg  [1:0]    op_mode;              // op_mode_bit_high, op_mode_bit_low
    reg  [5:0]    prescaler_mode_reg;   // clock and edge selection
    reg  [6:0]    out_ctl;              // output control, trigger bit not stored
    reg  [CW-1:0] compare_capture_a;    // compare a / capture a
    reg  [CW-1:0] compare_capture_b;    // compare b / capture b
    reg  [CW-1:0] count_register;       // the counter
    reg  [3:0]    irq_status;           // sticky event flags
    reg  [3:0]    irq_mask;             // one masks the event

    // internal state
    reg  [7:0]    div;                  // prescaler divider
    reg           running_d;            // running, one cycle late
    reg           out_level;            // timer output flip-flop
    reg           os_active;            // one-shot pulse in progress

    // address decode shared by reads and writes
    function is_mapped;
        input [7:0] a;
        begin
            if (a == `OFF_MODE)          is_mapped = 1'b1;
            else if (a == `OFF_PRESCALE) is_mapped = 1'b1;
            else if (a == `OFF_OUTCTL)   is_mapped = 1'b1;
            else if (a == `OFF_CMP_A)    is_mapped = 1'b1;
            else if (a == `OFF_CMP_B)    is_mapped = 1'b1;
            else if (a == `OFF_COUNT)    is_mapped = 1'b1;
            else if (a == `OFF_IRQ_STAT) is_mapped = 1'b1;
            else if (a == `OFF_IRQ_MASK) is_mapped = 1'b1;
            else                         is_mapped = 1'b0;
        end
    endfunction

    // bus strobes; the slave never stalls
    wire wr_en  = psel & penable & pwrite;              // write takes effect
    wire setup  = psel & ~penable;                      // setup phase
    assign pready  = 1'b1;
    assign pslverr = psel & penable & ~is_mapped(paddr);

    // decoded writes
    wire wr_mode   = wr_en & (paddr == `OFF_MODE);
    wire wr_pre    = wr_en & (paddr == `OFF_PRESCALE);
    wire wr_oc     = wr_en & (paddr == `OFF_OUTCTL);
    wire wr_cmp_a  = wr_en & (paddr == `OFF_CMP_A);
    wire wr_cmp_b  = wr_en & (paddr == `OFF_CMP_B);
    wire wr_stat   = wr_en & (paddr == `OFF_IRQ_STAT);
    wire wr_mask   = wr_en & (paddr == `OFF_IRQ_MASK);

    // field views
    wire       running  = (op_mode != `MODE_STOP);
    wire [1:0] cks      = prescaler_mode_reg[`PS_CKS_HI:`PS_CKS_LO];
    wire [1:0] esel_a   = prescaler_mode_reg[`PS_EDGE_A_HI:`PS_EDGE_A_LO];
    wire [1:0] esel_b   = prescaler_mode_reg[`PS_EDGE_B_HI:`PS_EDGE_B_LO];
    wire       out_en   = out_ctl[`OC_OUT_EN];
    wire       inv_a    = out_ctl[`OC_INV_A];
    wire       inv_b    = out_ctl[`OC_INV_B];                        // invert_on_b_match_enable
    wire       oneshot  = out_ctl[`OC_ONESHOT];
    wire       cap_a_en = out_ctl[`OC_CAP_A];
    wire       cap_b_en = out_ctl[`OC_CAP_B];

    // edge detectors on the two inputs
    wire edge_a;    // valid edge on edge_input_a
    wire edge_b;    // valid edge on shared_port_pin_in

    edge_sense u_edge_a (
        .clk        (pclk),
        .rst_n      (presetn),
        .pin        (edge_input_a),
        .enable     (running),
        .edge_sel   (esel_a),
        .edge_pulse (edge_a)
    );

    // the shared pin is an edge input only while the output is off
    edge_sense u_edge_b (
        .clk        (pclk),
        .rst_n      (presetn),
        .pin        (shared_port_pin_in),
        .enable     (running & ~out_en),
        .edge_sel   (esel_b),
        .edge_pulse (edge_b)
    );

    // shared pin driven by the timer only when the output is enabled
    assign shared_port_pin_out  = out_level;
    assign shared_port_pin_oe_n = ~out_en;

    // count clock enable from the divider or from edge a
    reg tick;
    always @* begin
        if (!running)
            tick = 1'b0;
        else if (cks == `CKS_EDGE_A)
            tick = edge_a;
        else if (cks == `CKS_DIV2)
            tick = ((div & `DIV_MASK2) == `DIV_MASK2);
        else if (cks == `CKS_DIV8)
            tick = ((div & `DIV_MASK8) == `DIV_MASK8);
        else
            tick = ((div & `DIV_MASK32) == `DIV_MASK32);
    end

    // compare matches, seen on the count clock
    wire match_a = tick & (count_register == compare_capture_a);
    wire match_b = tick & (count_register == compare_capture_b);

    // one-shot triggers; ignored while a pulse is in progress
    wire soft_trig = wr_oc & pwdata[`OC_SOFT_TRIG] & oneshot & running
                     & ~os_active;
    wire ext_trig  = edge_a & oneshot & running & ~os_active;
    wire os_start  = soft_trig | ext_trig;

    // clear and start conditions
    wire clear_cnt = os_start
                   | ((op_mode == `MODE_EDGE_CLR) & edge_a)
                   | ((op_mode == `MODE_MATCH_CLR) & match_a);

    // start of counting, for the initial ppg level
    wire start = running & ~running_d;

    // divider free-runs while the counter runs, restarts on stop
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div       <= `DIV_RST;
            running_d <= 1'b0;
        end else begin
            running_d <= running;
            if (!running)
                div <= `DIV_RST;
            else
                div <= div + 8'h01;
        end
    end

    // counter: counts on ticks, clears on trigger or match
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count_register <= `COUNT_RST;
        end else if (!running) begin
            count_register <= `COUNT_RST;            // stopped counter sits at zero
        end else if (clear_cnt) begin
            count_register <= `COUNT_RST;
        end else if (tick) begin
            count_register <= count_register + {{(CW-1){1'b0}}, 1'b1};
        end
    end

    // timer output flip-flop and one-shot state
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            out_level <= 1'b0;
            os_active <= 1'b0;
        end else if (!running) begin
            out_level <= 1'b0;                       // output idles low when stopped
            os_active <= 1'b0;
        end else if (oneshot) begin
            if (os_start) begin
                out_level <= 1'b0;
                os_active <= 1'b1;
            end else if (os_active && match_a) begin
                out_level <= 1'b0;                   // pulse ends on match a
                os_active <= 1'b0;
            end else if (os_active && match_b) begin
                out_level <= 1'b1;                   // pulse starts on match b
            end
        end else if (start && op_mode == `MODE_MATCH_CLR) begin
            out_level <= 1'b1;                       // ppg opens in its active phase
        end else begin
            // active from match a through match b: b+1 of a+1 counts
            out_level <= out_level ^ ((match_a & inv_a) ^ (match_b & inv_b));
        end
    end

    // mode, prescaler and output control
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            op_mode            <= `MODE_RST;
            prescaler_mode_reg <= `PRESCALE_RST;
            out_ctl            <= `OUTCTL_RST;
        end else begin
            if (wr_mode)
                op_mode <= pwdata[1:0];
            if (wr_pre)
                prescaler_mode_reg <= pwdata[5:0];
            if (wr_oc) begin
                out_ctl <= pwdata[6:0];
                out_ctl[`OC_SOFT_TRIG] <= 1'b0;
            end
        end
    end

    // compare registers; a capture wins over a software write
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            compare_capture_a <= `CMP_RST;
            compare_capture_b <= `CMP_RST;
        end else begin
            if (cap_a_en && edge_a)
                compare_capture_a <= count_register;
            else if (wr_cmp_a)
                compare_capture_a <= pwdata[CW-1:0];
            if (cap_b_en && edge_b)
                compare_capture_b <= count_register;
            else if (wr_cmp_b)
                compare_capture_b <= pwdata[CW-1:0];
        end
    end

    // events that set sticky flags
    wire [3:0] irq_set = {edge_b, edge_a, match_b, match_a};
    wire [3:0] irq_clr = wr_stat ? pwdata[3:0] : 4'h0;

    // sticky status with write-one-to-clear; a new event beats the clear
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_status <= `STAT_RST;
            irq_mask   <= `MASK_RST;
            irq        <= 1'b0;
        end else begin
            irq_status <= (irq_status & ~irq_clr) | irq_set;
            if (wr_mask)
                irq_mask <= pwdata[3:0];
            irq <= |(irq_status & ~irq_mask);
        end
    end

    // read data captured in the setup phase, shown in the access phase
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h00000000;
        end else if (setup && !pwrite) begin
            if (paddr == `OFF_MODE)
                prdata <= {30'h00000000, op_mode};
            else if (paddr == `OFF_PRESCALE)
                prdata <= {26'h0000000, prescaler_mode_reg};
            else if (paddr == `OFF_OUTCTL)
                prdata <= {25'h0000000, out_ctl};    // trigger bit is always zero
            else if (paddr == `OFF_CMP_A)
                prdata <= {{(32-CW){1'b0}}, compare_capture_a};
            else if (paddr == `OFF_CMP_B)
                prdata <= {{(32-CW){1'b0}}, compare_capture_b};
            else if (paddr == `OFF_COUNT)
                prdata <= {{(32-CW){1'b0}}, count_register};
            else if (paddr == `OFF_IRQ_STAT)
                prdata <= {28'h0000000, irq_status};
            else if (paddr == `OFF_IRQ_MASK)
                prdata <= {28'h0000000, irq_mask};
            else
                prdata <= 32'h00000000;              // unmapped reads zero
        end
    end

endmodule // timer16_ppg_oneshot_capture

`default_nettype wire

// file: test/timer16_ppg_chk.sv
// port checker for the 16-bit timer with apb registers
// assumes bind to the timer top and the map header on the include path
`include "timer16_map.vh"
`timescale 1ns/1ps
`default_nettype none
module timer16_ppg_chk #(
    parameter CW = 16                        // counter width
) (
    input wire logic        pclk,                 // clock
    input wire logic        presetn,              // reset, active low
    input wire logic        psel,                 // apb select
    input wire logic        penable,              // apb access phase
    input wire logic        pwrite,               // apb direction
    input wire logic [7:0]  paddr,                // apb address
    input wire logic [31:0] pwdata,               // apb write data
    input wire logic [31:0] prdata,               // apb read data
    input wire logic        pready,               // apb ready
    input wire logic        pslverr,              // apb error
    input wire logic        edge_input_a,         // input pin a
    input wire logic        shared_port_pin_in,   // shared pin level
    input wire logic        shared_port_pin_out,  // timer output
    input wire logic        shared_port_pin_oe_n, // shared pin enable
    input wire logic        irq                   // interrupt
);
    wire        acc = psel && penable; // access phase
    logic [1:0] mode_w;                // last mode written
    logic [1:0] stop_cnt;              // cycles stopped, saturating
    // follow mode writes and count how long the counter is stopped
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode_w <= 2'h0;
            stop_cnt <= 2'h0;
        end else begin
            if (acc && pwrite && paddr == `OFF_MODE)
                mode_w <= pwdata[1:0];
            if (mode_w != `MODE_STOP)
                stop_cnt <= 2'h0;
            else if (stop_cnt != 2'h3)
                stop_cnt <= stop_cnt + 2'h1;
        end
    end
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // a control write that sets or clears the output enable
    sequence s_ctl_wr(logic en);
        acc && pwrite && paddr == `OFF_OUTCTL && pwdata[`OC_OUT_EN] == en;
    endsequence
    // a read access to one address
    sequence s_rd(logic [7:0] a);
        acc && !pwrite && paddr == a;
    endsequence
    a_ready_high: assert property (pready) else $error("pready low");
    a_slverr_map: assert property (acc && paddr > `OFF_IRQ_MASK && paddr[1:0] == 2'h0
        |-> pslverr) else $error("unmapped access without error");
    a_mapped_ok: assert property (acc && paddr <= `OFF_IRQ_MASK && paddr[1:0] == 2'h0
        |-> !pslverr) else $error("mapped access with error");
    a_unmapped_zero: assert property (acc && !pwrite && pslverr |-> prdata == 32'h0)
        else $error("unmapped read not zero");
    a_prdata_hold: assert property (!(psel && !penable) |=> $stable(prdata))
        else $error("read data moved outside a setup");
    a_irq_masked: assert property (acc && pwrite && paddr == `OFF_IRQ_MASK
        && pwdata[3:0] == 4'hF |-> ##2 !irq) else $error("irq while all masked");
    a_oe_on: assert property (s_ctl_wr(1'b1) |=> !shared_port_pin_oe_n)
        else $error("shared pin not driven");
    a_oe_off: assert property (s_ctl_wr(1'b0) |=> shared_port_pin_oe_n)
        else $error("shared pin still driven");
    a_trig_zero: assert property (s_rd(`OFF_OUTCTL) |-> !prdata[`OC_SOFT_TRIG])
        else $error("soft trigger read as one");
    a_count_stop: assert property (s_rd(`OFF_COUNT) && stop_cnt == 2'h3
        |-> prdata == 32'h0) else $error("count moves while stopped");
endmodule // timer16_ppg_chk
bind timer16_ppg_oneshot_capture timer16_ppg_chk #(.CW(CW)) u_chk (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .edge_input_a(edge_input_a), .shared_port_pin_in(shared_port_pin_in),
    .shared_port_pin_out(shared_port_pin_out),
    .shared_port_pin_oe_n(shared_port_pin_oe_n), .irq(irq));
`default_nettype wire

// file: test/pin_partner.sv
// far-side model of the timer pins: input a and the shared pin
// assumes the bench sets wanted levels; the shared pin wire is resolved here
`timescale 1ns/1ps
`default_nettype none
module pin_partner (
    input  wire logic pclk,   // clock for pin changes
    input  wire logic want_a, // wanted level of input a
    input  wire logic want_b, // wanted level of shared pin
    input  wire logic out,    // timer output level
    input  wire logic oe_n,   // low while timer drives shared pin
    output var  logic pin_a,  // input a wire
    output wire logic pin_b   // shared pin wire
);
    // input a changes just after a clock edge
    always_ff @(posedge pclk) pin_a <= want_a;
    // the model lets go of the shared pin while the timer drives it
    assign pin_b = oe_n ? want_b : out;
endmodule // pin_partner
`default_nettype wire

// file: test/timer16_ppg_oneshot_capture_tb_top.sv
// self-checking bench for the 16-bit timer with apb registers
// assumes map header on include path; partner and checker compiled before
`include "timer16_map.vh"
`timescale 1ns/1ps
`default_nettype none
module timer16_ppg_oneshot_capture_tb_top;
    logic        pclk, presetn, psel, penable, pwrite; // clock, reset, apb controls
    logic [7:0]  paddr;        // apb address
    logic [31:0] pwdata, rd;   // apb write data, last read data
    wire  [31:0] prdata;       // apb read data
    wire         pready, pslverr, pin_a, pin_b, tout, oe_n, irq; // design side wires
    logic        want_a, want_b, err; // wanted pin levels, last error
    int          errors, total_checks;
    int          cyc = 0;      // cycles since start
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin errors++; \
    $display("Error %s expected %0h seen %0h", nm, e, g); end end
    timer16_ppg_oneshot_capture DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .edge_input_a(pin_a),
        .shared_port_pin_in(pin_b), .shared_port_pin_out(tout),
        .shared_port_pin_oe_n(oe_n), .irq(irq));
    pin_partner u_pins (.pclk(pclk), .want_a(want_a), .want_b(want_b), .out(tout),
        .oe_n(oe_n), .pin_a(pin_a), .pin_b(pin_b));
    // 25 ns clock
    initial begin
        pclk = 1'b0;
        forever #12.5 pclk = ~pclk;
    end
    // cut a hang short
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            errors++;
            give_verdict();
        end
    end
    // one apb transfer, then one idle cycle
    task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    // cycles while the timer output stays at v, bounded
    task run_len(input logic v, output int n);
        n = 0;
        while (tout === v && n < 100) begin
            @(posedge pclk);
            n++;
        end
    endtask
    // reset values of all registers, then an unmapped word
    task t_reset();
        for (int i = 0; i < 8; i++) begin
            apb(1'b0, 8'(i * 4), 32'h0);
            `CHK("reset value", (i == 7) ? 32'h0000000F : 32'h00000000, rd)
        end
        apb(1'b0, 8'h40, 32'h0);
        `CHK("unmapped error", 1'b1, err)
        `CHK("unmapped data", 32'h00000000, rd)
        `CHK("pin released", 1'b1, oe_n)
    endtask
    // input a high since reset: first start sees a rise, a restart does not
    task t_edge_a();
        wr(`OFF_PRESCALE, 32'h00000004);
        wr(`OFF_MODE, 32'h00000001);
        repeat (8) @(posedge pclk);
        apb(1'b0, `OFF_IRQ_STAT, 32'h0);
        `CHK("first rise", 1'b1, rd[`IRQ_EDGE_A])
        apb(1'b0, `OFF_COUNT, 32'h0);
        `CHK("running", 1'b1, rd != 32'h0)
        wr(`OFF_MODE, 32'h0);
        wr(`OFF_IRQ_STAT, 32'h0000000F);
        wr(`OFF_MODE, 32'h00000001);
        repeat (8) @(posedge pclk);
        apb(1'b0, `OFF_IRQ_STAT, 32'h0);
        `CHK("restart rise", 1'b0, rd[`IRQ_EDGE_A])
        wr(`OFF_MODE, 32'h0);
    endtask
    // input a as count clock in free mode: three rises count three
    task t_events();
        wr(`OFF_PRESCALE, 32'h00000007);
        wr(`OFF_MODE, 32'h00000001);
        repeat (3) begin
            want_a <= 1'b0;
            repeat (4) @(posedge pclk);
            want_a <= 1'b1;
            repeat (4) @(posedge pclk);
        end
        repeat (4) @(posedge pclk);
        apb(1'b0, `OFF_COUNT, 32'h0);
        `CHK("event count", 32'h00000003, rd)
        wr(`OFF_MODE, 32'h0);
    endtask
    // both pins as capture inputs on pclk/8: rise on a, fall on b 16 cycles later
    task t_capture();
        int ca;
        want_a <= 1'b0;
        want_b <= 1'b1;
        wr(`OFF_PRESCALE, 32'h00000005);
        wr(`OFF_OUTCTL, 32'h00000060);
        wr(`OFF_MODE, 32'h00000001);
        want_a <= 1'b1;
        repeat (16) @(posedge pclk);
        want_b <= 1'b0;
        repeat (8) @(posedge pclk);
        apb(1'b0, `OFF_CMP_A, 32'h0);
        ca = rd;
        apb(1'b0, `OFF_CMP_B, 32'h0);
        `CHK("pulse width", 2, rd - ca)
        wr(`OFF_MODE, 32'h0);
    endtask
    // ppg a=5 b=1 on pclk/2, then b=2 rewritten while counting; match b irq
    task t_ppg();
        int h;
        int l;
        wr(`OFF_CMP_A, 32'h00000005);
        wr(`OFF_CMP_B, 32'h00000001);
        wr(`OFF_PRESCALE, 32'h00000020);
        wr(`OFF_OUTCTL, 32'h00000007);
        wr(`OFF_IRQ_STAT, 32'h0000000F);
        wr(`OFF_IRQ_MASK, 32'h0000000D);
        wr(`OFF_MODE, 32'h00000003);
        `CHK("pin driven", 1'b0, oe_n)
        @(posedge pclk);
        run_len(1'b1, h);
        run_len(1'b0, h);
        run_len(1'b1, h);
        run_len(1'b0, l);
        `CHK("ppg high", 4, h)
        `CHK("ppg period", 12, h + l)
        `CHK("match irq", 1'b1, irq)
        wr(`OFF_IRQ_MASK, 32'h0000000F);
        repeat (2) @(posedge pclk);
        `CHK("irq masked", 1'b0, irq)
        apb(1'b0, `OFF_IRQ_STAT, 32'h0);
        `CHK("match b flag", 1'b1, rd[`IRQ_MATCH_B])
        `CHK("edge b ignored", 1'b0, rd[`IRQ_EDGE_B])
        // b=2 gives equal halves, so the phase after the rewrite does not matter
        wr(`OFF_OUTCTL, 32'h00000003);
        wr(`OFF_IRQ_MASK, 32'h0000000F);
        wr(`OFF_CMP_B, 32'h00000002);
        repeat (2) @(posedge pclk);
        wr(`OFF_OUTCTL, 32'h00000007);
        wr(`OFF_IRQ_STAT, 32'h00000002);
        wr(`OFF_IRQ_MASK, 32'h0000000D);
        run_len(1'b1, h);
        run_len(1'b0, h);
        run_len(1'b1, h);
        run_len(1'b0, l);
        `CHK("new width", 6, h)
        `CHK("new period", 12, h + l)
        wr(`OFF_MODE, 32'h0);
        wr(`OFF_IRQ_MASK, 32'h0000000D);
        repeat (2) @(posedge pclk);
        `CHK("irq unmasked", 1'b1, irq)
        wr(`OFF_IRQ_STAT, 32'h00000002);
        repeat (2) @(posedge pclk);
        `CHK("irq cleared", 1'b0, irq)
        wr(`OFF_OUTCTL, 32'h0);
    endtask
    // one-shot a=8 b=3: soft trigger, then a fall on input a
    task t_oneshot();
        int h;
        wr(`OFF_CMP_A, 32'h00000008);
        wr(`OFF_CMP_B, 32'h00000003);
        wr(`OFF_PRESCALE, 32'h00000000);
        wr(`OFF_OUTCTL, 32'h00000009);
        wr(`OFF_MODE, 32'h00000002);
        wr(`OFF_OUTCTL, 32'h00000019);
        apb(1'b0, `OFF_OUTCTL, 32'h0);
        `CHK("trigger reads zero", 32'h00000009, rd)
        run_len(1'b0, h);
        run_len(1'b1, h);
        `CHK("soft pulse", 10, h)
        repeat (20) @(posedge pclk);
        want_a <= 1'b0;
        run_len(1'b0, h);
        run_len(1'b1, h);
        `CHK("external pulse", 10, h)
        want_a <= 1'b1;
        wr(`OFF_MODE, 32'h0);
    endtask
    // report counts and end the run
    task give_verdict();
        $display("checks %0d errors %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    // reset for two cycles, then the scenarios
    initial begin
        {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
        {want_a, want_b, errors, total_checks} = {1'b1, 1'b0, 64'h0};
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        t_reset();
        t_edge_a();
        t_events();
        t_capture();
        t_ppg();
        t_oneshot();
        give_verdict();
    end
endmodule // timer16_ppg_oneshot_capture_tb_top
`default_nettype wire
